/* File: verilog/dma_consts.svh */
// Purpose: Constants shared by the transfer controller files
// Assumes: Included by bare name; guarded against double inclusion
// Notes:   Channel counts, widths, address and count constants only
`ifndef DMA_CONSTS_SVH
`define DMA_CONSTS_SVH
`define N_CH 4
`define N_PAIR 2
`define ADDR_W 24
`define IO_W 8
`define CNT_W 16
`define DATA_W 16
`define BLK_W 8
`define IO_HI 16'hFFFF
`define STEP_BYTE 24'h000001
`define STEP_WORD 24'h000002
`define CNT_LAST 16'h0001
`define BLK_LAST 8'h01
`endif

/* File: verilog/dma_pkg.sv */
// Purpose: Types of the transfer controller
// Assumes: Constants come from the shared header
// Notes:   State codes are Gray along idle, read, write, next
`include "dma_consts.svh"
package dma_pkg;
	typedef enum logic [2:0] {
		TRG_TMR0, TRG_TMR1, TRG_TMR2, TRG_TMR3,
		TRG_SER_TX, TRG_SER_RX, TRG_EXT, TRG_AUTO
	} trig_type;
	typedef enum logic [1:0] {SM_IO = 2'h0, SM_IDLE = 2'h1, SM_RPT = 2'h2} smode_type;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00, ST_RD = 2'b01, ST_WR = 2'b11, ST_NEXT = 2'b10
	} state_type;
endpackage : dma_pkg

/* File: verilog/arb_if.sv */
// Purpose: Request and grant bundle between engine and arbiter
// Assumes: One clock domain
// Notes:   take clears the granted pending flag
`timescale 1ns/10ps
interface arb_if #(parameter int N = 4);
	logic                 run;
	logic [N-1:0]         req;
	logic                 take;
	logic [N-1:0]         pend;
	logic                 gvld;
	logic [$clog2(N)-1:0] gidx;
	modport arb (input run, req, take, output pend, gvld, gidx);
	modport eng (output run, req, take, input pend, gvld, gidx);
endinterface : arb_if

/* File: verilog/req_arbiter.sv */
// Purpose: Pending request latch and fixed priority grant
// Assumes: Requests are one-cycle events or held levels
// Notes:   A set in the clearing cycle survives
`timescale 1ns/10ps
`include "dma_consts.svh"
module req_arbiter #(
	parameter int N = `N_CH
) (
	input  logic clk_i,
	input  logic resetn_i,
	arb_if.arb   a
);
	localparam int IW = $clog2(N);
	logic [N-1:0] pend_r;
	logic [N-1:0] pend_nxt;

	// ----------------------------------------
	// Pending flags
	// ----------------------------------------
	always_comb begin
		pend_nxt = pend_r;
		if (a.take) begin
			pend_nxt[a.gidx] = 1'b0;
		end
		pend_nxt = pend_nxt | a.req;
	end

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			pend_r <= '0;
		end else if (a.run) begin
			pend_r <= pend_nxt;
		end
	end

	// Lowest index wins; a starved high channel is the price of simplicity
	always_comb begin
		a.gvld = |pend_r;
		a.gidx = '0;
		for (int i = N - 1; i >= 0; i--) begin
			if (pend_r[i]) begin
				a.gidx = IW'(i);
			end
		end
	end
	assign a.pend = pend_r;

	property p_prio;
		@(posedge clk_i) disable iff (!resetn_i)
		a.gvld |-> ((pend_r & ~({N{1'b1}} << a.gidx)) == '0) && pend_r[a.gidx];
	endproperty
	a_prio: assert property (p_prio) else $error("grant not lowest pending");

	property p_set_wins;
		@(posedge clk_i) disable iff (!resetn_i)
		a.run && a.take && a.req[a.gidx] |=> pend_r[$past(a.gidx)];
	endproperty
	a_set_wins: assert property (p_set_wins) else $error("request lost at clear");
endmodule : req_arbiter

/* File: verilog/transfer_controller.sv */
// Purpose: Four-channel memory transfer engine with short and full modes
// Assumes: Settings are static while a channel is armed; bus answers with ack
// Notes:   One unit moves as a read then a write; bus_lock_o marks a held bus
`timescale 1ns/10ps
`include "dma_consts.svh"
module transfer_controller (
	input  logic                  clk_i,
	input  logic                  resetn_i,
	input  logic                  clk_en_i,
	input  logic                  module_stop_i,
	input  logic [1:0]            mode_select_bit_hi_i,
	input  logic [1:0]            mode_select_bit_lo_i,
	input  logic [3:0]            start_i,
	input  dma_pkg::trig_type     trig_sel_i [4],
	input  dma_pkg::smode_type    smode_i [4],
	input  logic [1:0]            block_mode_i,
	input  logic [1:0]            burst_i,
	input  logic [1:0]            fixed_dst_i,
	input  logic [3:0]            word_i,
	input  logic [3:0]            dec_i,
	input  logic [`ADDR_W-1:0]    mem_addr_i [4],
	input  logic [`IO_W-1:0]      io_addr_i [4],
	input  logic [`CNT_W-1:0]     count_i [4],
	input  logic [3:0]            integrated_timer_unit_irq_i,
	input  logic                  serial_comm_interface_tx_empty_i,
	input  logic                  serial_comm_interface_rx_full_i,
	input  logic [1:0]            ext_req_i,
	input  logic                  bus_ack_i,
	input  logic [`DATA_W-1:0]    bus_rdata_i,
	output logic                  bus_req_o,
	output logic                  bus_lock_o,
	output logic                  bus_we_o,
	output logic                  bus_word_o,
	output logic [`ADDR_W-1:0]    bus_addr_o,
	output logic [`DATA_W-1:0]    bus_wdata_o,
	output logic [3:0]            active_o,
	output logic [3:0]            done_o
);
	import dma_pkg::*;

	logic                 run;
	logic [1:0]           full;
	logic [1:0]           x1_r, x2_r, x3_r, xl_r, xl_nxt, ext_ev;
	logic [`ADDR_W-1:0]   mar_r [4], mar_nxt [4], mini_r [4], mini_nxt [4];
	logic [`CNT_W-1:0]    cnt_r [4], cnt_nxt [4], cini_r [4], cini_nxt [4];
	logic [`BLK_W-1:0]    blk_r [2], blk_nxt [2];
	logic [3:0]           en_r, en_nxt, done_r, done_nxt;
	logic [1:0]           auto_r, auto_nxt;
	state_type            st_r, st_nxt;
	logic [1:0]           cur_r, cur_nxt, sel;
	logic                 more_r, more_nxt, cur_full;
	logic                 req_r, req_nxt, lock_r, lock_nxt, we_r, we_nxt;
	logic                 word_r, word_nxt;
	logic [`ADDR_W-1:0]   addr_r, addr_nxt, src, dst;
	logic [`DATA_W-1:0]   data_r, data_nxt;

	arb_if #(.N(`N_CH)) arb ();

	req_arbiter #(.N(`N_CH)) u_arb (
		.clk_i    (clk_i),
		.resetn_i (resetn_i),
		.a        (arb)
	);

	function automatic logic fire(trig_type t, logic [3:0] tm, logic tx, logic rx, logic ex);
		case (t)
			TRG_SER_TX: fire = tx;
			TRG_SER_RX: fire = rx;
			TRG_EXT:    fire = ex;
			TRG_AUTO:   fire = 1'b0;
			default:    fire = tm[t[1:0]];
		endcase
	endfunction : fire

	function automatic logic [`ADDR_W-1:0] stepped(logic [`ADDR_W-1:0] a, smode_type m,
		logic w, logic d);
		logic [`ADDR_W-1:0] s;
		s = w ? `STEP_WORD : `STEP_BYTE;
		if (m == SM_IDLE) begin
			stepped = a;
		end else begin
			stepped = d ? a - s : a + s;
		end
	endfunction : stepped

	// Module stop freezes everything, like the clock enable
	assign run     = clk_en_i & ~module_stop_i;
	assign arb.run = run;
	assign full    = mode_select_bit_hi_i & mode_select_bit_lo_i;

	// ----------------------------------------
	// External request pins
	// ----------------------------------------
	// A pin edge counts once the second and third stages agree
	assign xl_nxt = ((x2_r ~^ x3_r) & x3_r) | ((x2_r ^ x3_r) & xl_r);
	assign ext_ev = xl_nxt & ~xl_r;

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			x1_r <= 2'h0;
			x2_r <= 2'h0;
			x3_r <= 2'h0;
			xl_r <= 2'h0;
		end else if (run) begin
			x1_r <= ext_req_i;
			x2_r <= x1_r;
			x3_r <= x2_r;
			xl_r <= xl_nxt;
		end
	end

	// ----------------------------------------
	// Trigger decode
	// ----------------------------------------
	for (genvar c = 0; c < `N_CH; c++) begin : g_req
		localparam int P = c / 2;
		logic hit;
		assign hit = fire(trig_sel_i[c], integrated_timer_unit_irq_i,
			serial_comm_interface_tx_empty_i, serial_comm_interface_rx_full_i,
			ext_ev[P]);
		always_comb begin
			if (full[P]) begin
				if (c % 2 == 1) begin
					arb.req[c] = 1'b0;
				end else if (block_mode_i[P]) begin
					arb.req[c] = en_r[c] & hit & (trig_sel_i[c] <= TRG_TMR3
						|| trig_sel_i[c] == TRG_EXT);
				end else begin
					arb.req[c] = en_r[c] & (auto_r[P]
						| (hit & (trig_sel_i[c] == TRG_EXT)));
				end
			end else begin
				// The A channel of a short pair ignores the external pin
				arb.req[c] = en_r[c] & hit & ((trig_sel_i[c] != TRG_EXT)
					| (c % 2 == 1));
			end
		end
	end

	// ----------------------------------------
	// Address routing
	// ----------------------------------------
	always_comb begin
		sel      = (st_r == ST_IDLE) ? arb.gidx : cur_r;
		cur_full = full[cur_r[1]];
		if (full[sel[1]]) begin
			src = mar_r[{sel[1], 1'b0}];
			dst = mar_r[{sel[1], 1'b1}];
		end else if (trig_sel_i[sel] == TRG_SER_RX) begin
			src = {`IO_HI, io_addr_i[sel]};
			dst = mar_r[sel];
		end else begin
			src = mar_r[sel];
			dst = {`IO_HI, io_addr_i[sel]};
		end
	end

	// ----------------------------------------
	// Transfer engine
	// ----------------------------------------
	always_comb begin
		logic [1:0] ca;
		logic [1:0] cb;
		logic       last;
		ca        = {cur_r[1], 1'b0};
		cb        = {cur_r[1], 1'b1};
		last      = 1'b0;
		mar_nxt   = mar_r;
		mini_nxt  = mini_r;
		cnt_nxt   = cnt_r;
		cini_nxt  = cini_r;
		blk_nxt   = blk_r;
		en_nxt    = en_r;
		auto_nxt  = auto_r;
		done_nxt  = 4'h0;
		st_nxt    = st_r;
		cur_nxt   = cur_r;
		more_nxt  = more_r;
		req_nxt   = req_r;
		lock_nxt  = lock_r;
		we_nxt    = we_r;
		word_nxt  = word_r;
		addr_nxt  = addr_r;
		data_nxt  = data_r;
		arb.take  = 1'b0;
		unique case (st_r)
			ST_IDLE: begin
				// Stale grants of finished channels are dropped here
				if (arb.gvld) begin
					arb.take = 1'b1;
					if (en_r[arb.gidx]) begin
						cur_nxt  = arb.gidx;
						req_nxt  = 1'b1;
						we_nxt   = 1'b0;
						addr_nxt = src;
						word_nxt = word_i[arb.gidx];
						lock_nxt = full[arb.gidx[1]] & (block_mode_i[arb.gidx[1]]
							| (auto_r[arb.gidx[1]] & burst_i[arb.gidx[1]]));
						st_nxt   = ST_RD;
					end
				end
			end
			ST_RD: begin
				if (bus_ack_i) begin
					data_nxt = bus_rdata_i;
					we_nxt   = 1'b1;
					addr_nxt = dst;
					st_nxt   = ST_WR;
				end
			end
			ST_WR: begin
				if (bus_ack_i) begin
					req_nxt  = 1'b0;
					we_nxt   = 1'b0;
					st_nxt   = ST_NEXT;
					more_nxt = 1'b0;
					if (cur_full) begin
						mar_nxt[ca] = stepped(mar_r[ca], smode_i[ca], word_i[ca], dec_i[ca]);
						mar_nxt[cb] = stepped(mar_r[cb], smode_i[cb], word_i[ca], dec_i[cb]);
						if (block_mode_i[cur_r[1]]) begin
							blk_nxt[cur_r[1]] = blk_r[cur_r[1]] - `BLK_LAST;
							more_nxt = blk_r[cur_r[1]] != `BLK_LAST;
							if (!more_nxt) begin
								blk_nxt[cur_r[1]] = cini_r[cb][`BLK_W-1:0];
								if (fixed_dst_i[cur_r[1]]) begin
									mar_nxt[cb] = mini_r[cb];
								end else begin
									mar_nxt[ca] = mini_r[ca];
								end
								cnt_nxt[ca] = cnt_r[ca] - `CNT_LAST;
								last        = cnt_r[ca] == `CNT_LAST;
							end
						end else begin
							cnt_nxt[ca] = cnt_r[ca] - `CNT_LAST;
							last        = cnt_r[ca] == `CNT_LAST;
							more_nxt    = auto_r[cur_r[1]] & burst_i[cur_r[1]];
						end
						if (last) begin
							// The B half of a full pair ends together with A
							en_nxt[ca]          = 1'b0;
							en_nxt[cb]          = 1'b0;
							auto_nxt[cur_r[1]]  = 1'b0;
							done_nxt[ca]        = 1'b1;
							more_nxt            = 1'b0;
						end
					end else begin
						mar_nxt[cur_r] = stepped(mar_r[cur_r], smode_i[cur_r],
							word_i[cur_r], dec_i[cur_r]);
						cnt_nxt[cur_r] = cnt_r[cur_r] - `CNT_LAST;
						if (cnt_r[cur_r] == `CNT_LAST) begin
							done_nxt[cur_r] = 1'b1;
							if (smode_i[cur_r] == SM_RPT) begin
								mar_nxt[cur_r] = mini_r[cur_r];
								cnt_nxt[cur_r] = cini_r[cur_r];
							end else begin
								en_nxt[cur_r] = 1'b0;
							end
						end
					end
				end
			end
			ST_NEXT: begin
				if (more_r) begin
					req_nxt  = 1'b1;
					addr_nxt = src;
					st_nxt   = ST_RD;
				end else begin
					lock_nxt = 1'b0;
					st_nxt   = ST_IDLE;
				end
			end
		endcase
		// Arming wins over a transfer finishing on the same channel
		for (int i = 0; i < `N_CH; i++) begin
			if (start_i[i]) begin
				mar_nxt[i]  = mem_addr_i[i];
				mini_nxt[i] = mem_addr_i[i];
				cnt_nxt[i]  = (smode_i[i] == SM_RPT && !full[i / 2])
					? {8'h00, count_i[i][7:0]} : count_i[i];
				cini_nxt[i] = cnt_nxt[i];
				en_nxt[i]   = 1'b1;
				if (i % 2 == 1) begin
					blk_nxt[i / 2] = count_i[i][`BLK_W-1:0];
				end else begin
					auto_nxt[i / 2] = full[i / 2] & ~block_mode_i[i / 2]
						& (trig_sel_i[i] == TRG_AUTO);
				end
			end
		end
	end

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			for (int i = 0; i < `N_CH; i++) begin
				mar_r[i]  <= '0;
				mini_r[i] <= '0;
				cnt_r[i]  <= '0;
				cini_r[i] <= '0;
			end
			blk_r[0] <= '0;
			blk_r[1] <= '0;
			en_r     <= 4'h0;
			auto_r   <= 2'h0;
			done_r   <= 4'h0;
			st_r     <= ST_IDLE;
			cur_r    <= 2'h0;
			more_r   <= 1'b0;
			req_r    <= 1'b0;
			lock_r   <= 1'b0;
			we_r     <= 1'b0;
			word_r   <= 1'b0;
			addr_r   <= '0;
			data_r   <= '0;
		end else if (run) begin
			mar_r  <= mar_nxt;
			mini_r <= mini_nxt;
			cnt_r  <= cnt_nxt;
			cini_r <= cini_nxt;
			blk_r  <= blk_nxt;
			en_r   <= en_nxt;
			auto_r <= auto_nxt;
			done_r <= done_nxt;
			st_r   <= st_nxt;
			cur_r  <= cur_nxt;
			more_r <= more_nxt;
			req_r  <= req_nxt;
			lock_r <= lock_nxt;
			we_r   <= we_nxt;
			word_r <= word_nxt;
			addr_r <= addr_nxt;
			data_r <= data_nxt;
		end
	end

	assign bus_req_o   = req_r;
	assign bus_lock_o  = lock_r;
	assign bus_we_o    = we_r;
	assign bus_word_o  = word_r;
	assign bus_addr_o  = addr_r;
	assign bus_wdata_o = data_r;
	assign active_o    = en_r;
	assign done_o      = done_r;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	property p_io_hi;
		@(posedge clk_i) disable iff (!resetn_i)
		st_r == ST_WR && !cur_full && trig_sel_i[cur_r] != TRG_SER_RX
			|-> bus_addr_o[23:8] == `IO_HI;
	endproperty
	a_io_hi: assert property (p_io_hi) else $error("peripheral page wrong");

	property p_rx_dir;
		@(posedge clk_i) disable iff (!resetn_i)
		st_r == ST_RD && !cur_full && trig_sel_i[cur_r] == TRG_SER_RX
			|-> bus_addr_o[23:8] == `IO_HI && !bus_we_o;
	endproperty
	a_rx_dir: assert property (p_rx_dir) else $error("receive direction wrong");

	property p_step;
		@(posedge clk_i) disable iff (!resetn_i)
		run && st_r == ST_WR && bus_ack_i && !cur_full && !start_i[cur_r]
			&& smode_i[cur_r] == SM_IO && !dec_i[cur_r] && cnt_r[cur_r] != `CNT_LAST
			|=> mar_r[cur_r] == $past(mar_r[cur_r])
				+ ($past(word_i[cur_r]) ? `STEP_WORD : `STEP_BYTE);
	endproperty
	a_step: assert property (p_step) else $error("address step wrong");

	property p_idle_hold;
		@(posedge clk_i) disable iff (!resetn_i)
		run && st_r == ST_WR && bus_ack_i && !cur_full && !start_i[cur_r]
			&& smode_i[cur_r] == SM_IDLE
			|=> mar_r[cur_r] == $past(mar_r[cur_r]);
	endproperty
	a_idle_hold: assert property (p_idle_hold) else $error("idle address moved");

	property p_rpt;
		@(posedge clk_i) disable iff (!resetn_i)
		run && st_r == ST_WR && bus_ack_i && !cur_full && !start_i[cur_r]
			&& smode_i[cur_r] == SM_RPT && cnt_r[cur_r] == `CNT_LAST
			|=> cnt_r[cur_r] == cini_r[cur_r] && mar_r[cur_r] == mini_r[cur_r]
				&& en_r[cur_r] && done_o[cur_r];
	endproperty
	a_rpt: assert property (p_rpt) else $error("repeat reload wrong");

	property p_end;
		@(posedge clk_i) disable iff (!resetn_i)
		run && st_r == ST_WR && bus_ack_i && !cur_full && !start_i[cur_r]
			&& smode_i[cur_r] != SM_RPT && cnt_r[cur_r] == `CNT_LAST
			|=> !en_r[cur_r] && done_o[cur_r] ##1 !done_o[$past(cur_r, 2)];
	endproperty
	a_end: assert property (p_end) else $error("count end wrong");

	property p_full_a;
		@(posedge clk_i) disable iff (!resetn_i)
		st_r != ST_IDLE && cur_full |-> !cur_r[0] && full[cur_r[1]];
	endproperty
	a_full_a: assert property (p_full_a) else $error("full pair served by B");

	property p_stop;
		@(posedge clk_i) disable iff (!resetn_i)
		module_stop_i |=> st_r == $past(st_r) && bus_req_o == $past(bus_req_o);
	endproperty
	a_stop: assert property (p_stop) else $error("state moved while stopped");
endmodule : transfer_controller

/* File: testbench/bus_mem_model.sv */
// Purpose: Memory and peripheral side of the system bus seen by the controller
// Assumes: One bus cycle at a time; ack is a one-cycle pulse on the same clock
// Notes:   Read data is made from the address so that every unit can be traced
`timescale 1ns/10ps
module bus_mem_model (
	input  wire logic        clk_i,
	input  wire logic        resetn_i,
	input  wire logic [3:0]  delay_i,
	input  wire logic        req_i,
	input  wire logic        we_i,
	input  wire logic        word_i,
	input  wire logic [23:0] addr_i,
	input  wire logic [15:0] wdata_i,
	output logic             ack_o,
	output logic [15:0]      rdata_o
);
	logic [3:0]  wait_r;
	logic [23:0] log_addr [$];
	logic [15:0] log_data [$];
	logic        log_we   [$];
	logic        log_word [$];
	int          n_wr;

	task automatic clear();
		log_addr.delete();
		log_data.delete();
		log_we.delete();
		log_word.delete();
		n_wr = 0;
	endtask : clear

	// --------------------------------------------------------------------
	// Responder
	// --------------------------------------------------------------------
	// Outside an answer the data lines toggle, so a stale value is never read as good
	always @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			ack_o   <= 1'b0;
			wait_r  <= 4'h0;
			rdata_o <= 16'hA5A5;
		end else if (ack_o) begin
			ack_o   <= 1'b0;
			wait_r  <= 4'h0;
			rdata_o <= ~rdata_o;
		end else if (req_i && wait_r >= delay_i) begin
			ack_o   <= 1'b1;
			rdata_o <= we_i ? ~rdata_o : {~addr_i[7:0], addr_i[7:0]};
		end else begin
			wait_r  <= req_i ? wait_r + 4'h1 : 4'h0;
			rdata_o <= ~rdata_o;
		end
	end

	// Every completed cycle is logged for the bench to compare
	always @(posedge clk_i) begin
		if (resetn_i && req_i && ack_o) begin
			log_addr.push_back(addr_i);
			log_data.push_back(we_i ? wdata_i : rdata_o);
			log_we.push_back(we_i);
			log_word.push_back(word_i);
			if (we_i)
				n_wr++;
		end
	end
endmodule : bus_mem_model

/* File: testbench/four_channel_dma_overview_tb.sv */
// Purpose: Self-checking bench for the four-channel transfer controller
// Assumes: Bus partner is the memory model; clock enable high except in the halt test
// Notes:   Short-mode cases run from a table; full modes and reset by hand
`timescale 1ns/10ps
module four_channel_dma_overview_tb;
	import dma_pkg::*;
	typedef struct {
		int          ch;
		trig_type    t;
		smode_type   m;
		logic        w;
		logic        d;
		logic [23:0] mem;
		logic [7:0]  io;
		logic [15:0] cnt;
		logic [23:0] s0, d0, s1, d1;
		int          n_done;
		logic        act;
	} row_type;
	logic        clk_i, resetn_i, stop, tx, rx, ack, req, lock, we, bword, lock_seen, cen;
	logic [1:0]  sel_hi, sel_lo, blk, burst, fix, ext;
	logic [3:0]  start, word, dec, integrated_timer_unit, active, done, delay;
	logic [23:0] maddr [4];
	logic [23:0] addr;
	logic [7:0]  ioaddr [4];
	logic [15:0] cnt [4];
	logic [15:0] rdata, wdata;
	trig_type    trig_sel [4];
	smode_type   smode [4];
	row_type     rows [7];
	row_type     r;
	int          n_done [4];
	int          n_errors, n_tests, base;

	transfer_controller dut (.clk_i(clk_i), .resetn_i(resetn_i), .clk_en_i(cen),
		.module_stop_i(stop), .mode_select_bit_hi_i(sel_hi), .mode_select_bit_lo_i(sel_lo),
		.start_i(start), .trig_sel_i(trig_sel), .smode_i(smode), .block_mode_i(blk),
		.burst_i(burst), .fixed_dst_i(fix), .word_i(word), .dec_i(dec), .mem_addr_i(maddr),
		.io_addr_i(ioaddr), .count_i(cnt), .integrated_timer_unit_irq_i(integrated_timer_unit),
		.serial_comm_interface_tx_empty_i(tx), .serial_comm_interface_rx_full_i(rx),
		.ext_req_i(ext), .bus_ack_i(ack), .bus_rdata_i(rdata), .bus_req_o(req),
		.bus_lock_o(lock), .bus_we_o(we), .bus_word_o(bword), .bus_addr_o(addr),
		.bus_wdata_o(wdata), .active_o(active), .done_o(done));
	bus_mem_model mem (.clk_i(clk_i), .resetn_i(resetn_i), .delay_i(delay), .req_i(req),
		.we_i(we), .word_i(bword), .addr_i(addr), .wdata_i(wdata), .ack_o(ack),
		.rdata_o(rdata));

	always #5 clk_i = ~clk_i;
	always @(posedge clk_i) begin
		for (int i = 0; i < 4; i++)
			n_done[i] += (done[i] === 1'b1);
		if (lock === 1'b1)
			lock_seen = 1'b1;
	end

	// --------------------------------------------------------------------
	// Tasks
	// --------------------------------------------------------------------
	task automatic test_done();
		if (n_errors == 0 && n_tests > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : test_done

	task automatic chk(input logic ok, input string msg);
		n_tests++;
		if (ok !== 1'b1) begin
			n_errors++;
			$display("mismatch at %0t: %s", $time, msg);
		end
	endtask : chk

	task automatic do_reset();
		@(posedge clk_i);
		resetn_i <= 1'b0;
		{sel_hi, sel_lo, blk, burst, fix} <= 10'h000;
		dec <= 4'h0;
		lock_seen = 1'b0;
		n_done = '{default: 0};
		mem.clear();
		repeat (5) @(posedge clk_i);
		@(negedge clk_i);
		chk({req, lock, we, bword, addr, wdata, active, done} === '0, "outputs not cleared");
		@(posedge clk_i);
		resetn_i <= 1'b1;
	endtask : do_reset

	task automatic cfg(input int c, input trig_type t, input smode_type m, input logic w,
		input logic [23:0] a, input logic [7:0] io, input logic [15:0] n);
		trig_sel[c] <= t;
		smode[c] <= m;
		word[c] <= w;
		maddr[c] <= a;
		ioaddr[c] <= io;
		cnt[c] <= n;
	endtask : cfg

	task automatic arm(input logic [3:0] m);
		start <= m;
		@(posedge clk_i);
		start <= 4'h0;
		@(posedge clk_i);
		@(negedge clk_i);
		chk((active & m) === m, "channel not armed after start");
		@(posedge clk_i);
	endtask : arm

	// The external pin is held three cycles: the filter needs two agreeing stages
	task automatic fire(input trig_type t, input int p);
		@(posedge clk_i);
		case (t)
			TRG_SER_TX: tx <= 1'b1;
			TRG_SER_RX: rx <= 1'b1;
			TRG_EXT:    ext[p] <= 1'b1;
			default:    integrated_timer_unit[t[1:0]] <= 1'b1;
		endcase
		repeat ((t == TRG_EXT) ? 3 : 1) @(posedge clk_i);
		integrated_timer_unit <= 4'h0;
		{tx, rx, ext} <= 4'h0;
	endtask : fire

	task automatic wait_wr(input int n);
		int k;
		k = 0;
		while (mem.n_wr < n && k < 300) begin
			@(negedge clk_i);
			k++;
		end
		chk(mem.n_wr >= n, "bus cycles never completed");
		@(posedge clk_i);
	endtask : wait_wr

	task automatic settle();
		int k;
		k = 0;
		while (req !== 1'b0 && k < 300) begin
			@(negedge clk_i);
			k++;
		end
		repeat (3) @(posedge clk_i);
	endtask : settle

	task automatic chk_unit(input int k, input logic [23:0] s, input logic [23:0] d,
		input logic w);
		chk(mem.log_we[2*k] === 1'b0 && mem.log_addr[2*k] === s, "read address");
		chk(mem.log_we[2*k+1] === 1'b1 && mem.log_addr[2*k+1] === d, "write address");
		chk(mem.log_data[2*k+1] === {~s[7:0], s[7:0]}, "write data");
		chk(mem.log_word[2*k] === w, "transfer width");
	endtask : chk_unit

	// --------------------------------------------------------------------
	// Sequence
	// --------------------------------------------------------------------
	initial begin
		// Generous bound: the whole sequence needs under two thousand cycles
		repeat (20000) @(posedge clk_i);
		n_errors++;
		test_done();
	end

	initial begin
		clk_i = 1'b0;
		resetn_i = 1'b0;
		{stop, tx, rx, start, word, dec, integrated_timer_unit, ext, delay} = '0;
		cen = 1'b1;
		{sel_hi, sel_lo, blk, burst, fix} = 10'h000;
		trig_sel = '{default: TRG_TMR0};
		smode = '{default: SM_IO};
		maddr = '{default: 24'h000000};
		ioaddr = '{default: 8'h00};
		cnt = '{default: 16'h0001};
		n_errors = 0;
		n_tests = 0;
		rows = '{
			'{0, TRG_TMR0, SM_IO, 1'b0, 1'b0, 24'h000100, 8'h20, 16'h0002,
				24'h000100, 24'hFFFF20, 24'h000101, 24'hFFFF20, 1, 1'b0},
			'{1, TRG_TMR1, SM_IO, 1'b1, 1'b1, 24'h000200, 8'h22, 16'h0002,
				24'h000200, 24'hFFFF22, 24'h0001FE, 24'hFFFF22, 1, 1'b0},
			'{2, TRG_SER_TX, SM_IDLE, 1'b0, 1'b0, 24'h000300, 8'h24, 16'h0002,
				24'h000300, 24'hFFFF24, 24'h000300, 24'hFFFF24, 1, 1'b0},
			'{3, TRG_SER_RX, SM_IO, 1'b1, 1'b0, 24'h000400, 8'h26, 16'h0002,
				24'hFFFF26, 24'h000400, 24'hFFFF26, 24'h000402, 1, 1'b0},
			'{1, TRG_EXT, SM_IO, 1'b0, 1'b0, 24'hFFFFFE, 8'h28, 16'h0002,
				24'hFFFFFE, 24'hFFFF28, 24'hFFFFFF, 24'hFFFF28, 1, 1'b0},
			'{0, TRG_TMR3, SM_IDLE, 1'b1, 1'b1, 24'h000700, 8'h2C, 16'h0002,
				24'h000700, 24'hFFFF2C, 24'h000700, 24'hFFFF2C, 1, 1'b0},
			'{2, TRG_TMR2, SM_RPT, 1'b1, 1'b0, 24'h000600, 8'h2A, 16'h0001,
				24'h000600, 24'hFFFF2A, 24'h000600, 24'hFFFF2A, 2, 1'b1}};
		do_reset();
		sel_hi <= 2'h3;
		for (int i = 0; i < 7; i++) begin
			r = rows[i];
			mem.clear();
			base = n_done[r.ch];
			cfg(r.ch, r.t, r.m, r.w, r.mem, r.io, r.cnt);
			dec[r.ch] <= r.d;
			delay <= 4'(i % 3);
			arm(4'h1 << r.ch);
			fire(r.t, r.ch / 2);
			wait_wr(1);
			fire(r.t, r.ch / 2);
			wait_wr(2);
			settle();
			chk_unit(0, r.s0, r.d0, r.w);
			chk_unit(1, r.s1, r.d1, r.w);
			chk(n_done[r.ch] - base === r.n_done, "done pulse count");
			chk(active[r.ch] === r.act, "armed state after count");
		end
		do_reset();
		cfg(0, TRG_TMR0, SM_IO, 1'b0, 24'h000800, 8'h30, 16'h0001);
		cfg(3, TRG_TMR0, SM_IO, 1'b0, 24'h000900, 8'h32, 16'h0001);
		arm(4'h9);
		fire(TRG_TMR0, 0);
		wait_wr(2);
		chk_unit(0, 24'h000800, 24'hFFFF30, 1'b0);
		chk_unit(1, 24'h000900, 24'hFFFF32, 1'b0);
		do_reset();
		cfg(2, TRG_TMR2, SM_IDLE, 1'b1, 24'h000A00, 8'h34, 16'h0001);
		arm(4'h4);
		stop <= 1'b1;
		fire(TRG_TMR2, 1);
		repeat (20) @(posedge clk_i);
		@(negedge clk_i);
		chk(mem.n_wr === 0 && active[2] === 1'b1, "halted controller moved data");
		@(posedge clk_i);
		{stop, cen} <= 2'b00;
		fire(TRG_TMR2, 1);
		repeat (20) @(posedge clk_i);
		@(negedge clk_i);
		chk(mem.n_wr === 0 && active[2] === 1'b1, "disabled clock moved data");
		@(posedge clk_i);
		cen <= 1'b1;
		fire(TRG_TMR2, 1);
		wait_wr(1);
		chk_unit(0, 24'h000A00, 24'hFFFF34, 1'b1);
		for (int b = 1; b >= 0; b--) begin
			do_reset();
			{sel_hi, sel_lo, burst} <= {2'h1, 2'h1, 2'(b)};
			cfg(0, TRG_AUTO, SM_IO, 1'b1, 24'h001000, 8'h00, 16'h0003);
			cfg(1, TRG_AUTO, SM_IO, 1'b0, 24'h002000, 8'h00, 16'h0003);
			arm(4'h3);
			wait_wr(3);
			settle();
			for (int k = 0; k < 3; k++)
				chk_unit(k, 24'h001000 + 24'(2 * k), 24'h002000 + 24'(2 * k), 1'b1);
			chk(lock_seen === 1'(b) && active[1:0] === 2'h0, "bus hold mode");
			chk(n_done[0] + n_done[1] === 1 && mem.n_wr === 3, "full mode count");
		end
		for (int f = 1; f >= 0; f--) begin
			do_reset();
			{sel_hi, sel_lo, blk, fix} <= {6'h2A, 1'(f), 1'b0};
			cfg(2, TRG_TMR0, SM_IO, 1'b0, 24'h003000, 8'h00, 16'h0002);
			cfg(3, TRG_TMR0, SM_IO, 1'b0, 24'h004000, 8'h00, 16'h0002);
			arm(4'hC);
			for (int b = 0; b < 2; b++) begin
				fire(TRG_TMR0, 1);
				wait_wr(2 * b + 2);
				settle();
				chk(mem.n_wr === 2 * b + 2, "units per block");
			end
			for (int k = 0; k < 4; k++)
				chk_unit(k, 24'h003000 + 24'(f ? k : k % 2),
					24'h004000 + 24'(f ? k % 2 : k), 1'b0);
			chk(active[3:2] === 2'h0, "block count end");
		end
		test_done();
	end
endmodule : four_channel_dma_overview_tb
